/* logic/quad_enc_pkg.sv */
// Constants and types shared by the encoder output and the quadrature receiver.
// Assumes a single 50 MHz system clock and 14-bit angle samples.
package quad_enc_pkg;
   // ==========================================================
   // Angle and resolution
   localparam int ANGLE_W = 14;
   localparam logic [3:0] RES_CODE_MIN = 4'h3;
   localparam logic [3:0] RES_CODE_MAX = 4'hE;
   localparam logic [3:0] RES_CODE_TOP = 4'hE;
   localparam logic [3:0] RES_CODE_DEFAULT = 4'hE;
   localparam logic [3:0] RES_SHIFT_BASE = 4'h2;
   localparam int STEP_W = 16;
   localparam logic [STEP_W-1:0] STEP_ZERO = 16'h0000;
   // ==========================================================
   // Quadrature states, index = (first,second) Gray position
   localparam logic [1:0] QPOS_0 = 2'h0;
   localparam logic [1:0] QPOS_1 = 2'h1;
   localparam logic [1:0] QPOS_2 = 2'h2;
   localparam logic [1:0] QPOS_3 = 2'h3;
   // ==========================================================
   // Timing
   localparam int CLK_HZ = 50000000;
   localparam int SAMPLE_PERIOD_NS = 1000;
   localparam int SAMPLE_CYCLES = (SAMPLE_PERIOD_NS * (CLK_HZ / 1000000)) / 1000;
   // ==========================================================
   // Device sequencing states
   typedef enum logic [2:0] {
      ST_ZERO  = 3'b001,
      ST_SLEW  = 3'b010,
      ST_TRACK = 3'b100
   } enc_state_t;
endpackage : quad_enc_pkg

/* logic/quad_link_if.sv */
// Link between the encoder output and the quadrature receiver.
// Assumes both ends share clk_sys_i; the link is three plain wires.
`timescale 1ns/1ps
`default_nettype none
interface quad_link_if;
   logic chan_a;
   logic chan_b;
   logic marker;
   modport encoder
   (
      output chan_a,
      output chan_b,
      output marker
   );
   modport receiver
   (
      input chan_a,
      input chan_b,
      input marker
   );
endinterface : quad_link_if
`default_nettype wire

/* logic/incremental_encoder_output.sv */
// Incremental encoder output: angle samples in, quadrature channels and zero marker out.
// Assumes samples and configuration are synchronous to clk_sys_i.
// Link pins are registered; settled_o flags catch-up done.
// Functional notes
// - Channels: 50% duty, 2^N cycles per revolution
// - Second channel leads first by quarter cycle on increase
// - Marker once per revolution at zero
// - Each state spans 360/(4*2^N) degrees
// - Increasing angle: second-channel edge leads
// - Decreasing angle: first-channel edge leads
// - Receiver position wraps each revolution
// - States 00,01,11,10 Gray sequence
// - Only adjacent state transitions when slew limited
// - Code 3..14 gives N = 14 - code
// - Nonzero step interval enables slew limiting
// - Limited: walk every intervening state, then track
// - Samples every 1 us; interval limits
// - Start at zero state, catch up shortest way
// - Interval zero: jump straight to target
`timescale 1ns/1ps
`default_nettype none
module incremental_encoder_output
   import quad_enc_pkg::*;
(
   input wire logic clk_sys_i,
   input wire logic nrst_i,
   input wire logic [ANGLE_W-1:0] angle_i,
   input wire logic angle_valid_i,
   input wire logic [3:0] resolution_code_i,
   input wire logic [STEP_W-1:0] quadrature_step_interval_i,
   quad_link_if.encoder link,
   output logic settled_o
);
   // ==========================================================
   // Target state from angle
   logic [ANGLE_W-1:0] angle_ff;
   logic [3:0] shift;
   logic [ANGLE_W-1:0] bin_count;
   logic [ANGLE_W-1:0] target_count;
   logic [1:0] target_pos;
   logic [ANGLE_W-1:0] count_mask;
   logic slew_on;

   always_ff @(posedge clk_sys_i)
   begin
      if (!nrst_i)
      begin
         angle_ff <= '0;
      end
      else if (angle_valid_i)
      begin
         angle_ff <= angle_i;
      end
   end

   always_comb
   begin
      if (resolution_code_i >= RES_CODE_MIN && resolution_code_i <= RES_CODE_MAX)
      begin
         shift = resolution_code_i - RES_SHIFT_BASE;
      end
      else
      begin
         shift = RES_CODE_DEFAULT - RES_SHIFT_BASE;
      end
   end

   // Top N+2 angle bits give the quadrature count
   assign bin_count = angle_ff >> shift;
   assign target_count = bin_count;
   assign target_pos = target_count[1:0];
   assign count_mask = {ANGLE_W{1'b1}} >> shift;
   assign slew_on = (quadrature_step_interval_i != STEP_ZERO);

   // ==========================================================
   // Sequencer
   enc_state_t state_ff;
   enc_state_t nxt_state;
   logic [1:0] pos_ff;
   logic [1:0] nxt_pos;
   logic [STEP_W-1:0] timer_ff;
   logic step_ok;
   logic [ANGLE_W-1:0] cur_count_ff;
   logic [ANGLE_W-1:0] nxt_count;
   logic [ANGLE_W-1:0] fwd_dist;
   logic [ANGLE_W-1:0] back_dist;

   assign step_ok = (timer_ff == STEP_ZERO);
   // Distance to target each way round the wrap
   assign fwd_dist = (target_count - cur_count_ff) & count_mask;
   assign back_dist = (cur_count_ff - target_count) & count_mask;

   always_comb
   begin
      nxt_state = state_ff;
      nxt_pos = pos_ff;
      nxt_count = cur_count_ff;
      unique case (state_ff)
         ST_ZERO:
         begin
            if (slew_on)
            begin
               nxt_state = ST_SLEW;
            end
            else
            begin
               nxt_state = ST_TRACK;
               nxt_pos = target_pos;
               nxt_count = target_count;
            end
         end
         ST_SLEW, ST_TRACK:
         begin
            if (!slew_on)
            begin
               nxt_pos = target_pos;
               nxt_count = target_count;
               nxt_state = ST_TRACK;
            end
            else if (cur_count_ff == target_count)
            begin
               nxt_state = ST_TRACK;
            end
            else if (step_ok)
            begin
               // One state, shortest way round
               if (fwd_dist <= back_dist)
               begin
                  nxt_count = (cur_count_ff + 1'b1) & count_mask;
               end
               else
               begin
                  nxt_count = (cur_count_ff - 1'b1) & count_mask;
               end
               nxt_pos = nxt_count[1:0];
               nxt_state = ST_SLEW;
            end
         end
      endcase
   end

   always_ff @(posedge clk_sys_i)
   begin
      if (!nrst_i)
      begin
         state_ff <= ST_ZERO;
         pos_ff <= QPOS_0;
         cur_count_ff <= '0;
      end
      else
      begin
         state_ff <= nxt_state;
         pos_ff <= nxt_pos;
         cur_count_ff <= nxt_count;
      end
   end

   // ==========================================================
   // Step pacing
   always_ff @(posedge clk_sys_i)
   begin
      if (!nrst_i)
      begin
         timer_ff <= STEP_ZERO;
      end
      else if (nxt_pos != pos_ff)
      begin
         timer_ff <= quadrature_step_interval_i - 1'b1;
      end
      else if (!step_ok)
      begin
         timer_ff <= timer_ff - 1'b1;
      end
   end

   // ==========================================================
   // Pin drivers
   logic a_ff;
   logic b_ff;
   logic z_ff;
   logic settled_ff;

   always_ff @(posedge clk_sys_i)
   begin
      if (!nrst_i)
      begin
         a_ff <= 1'b0;
         b_ff <= 1'b0;
         z_ff <= 1'b1;
         settled_ff <= 1'b0;
      end
      else
      begin
         // Gray map 0:00 1:01 2:11 3:10, second leads on increase
         a_ff <= nxt_pos[1];
         b_ff <= nxt_pos[1] ^ nxt_pos[0];
         z_ff <= (nxt_count == '0);
         settled_ff <= (nxt_state == ST_TRACK) && (nxt_count == target_count);
      end
   end

   assign link.chan_a = a_ff;
   assign link.chan_b = b_ff;
   assign link.marker = z_ff;
   assign settled_o = settled_ff;
endmodule : incremental_encoder_output
`default_nettype wire

/* logic/quadrature_receiver.sv */
// Quadrature receiver: counts encoder states into a wrapping angle position.
// Assumes link pins are synchronous to clk_sys_i.
`timescale 1ns/1ps
`default_nettype none
module quadrature_receiver
   import quad_enc_pkg::*;
(
   input wire logic clk_sys_i,
   input wire logic nrst_i,
   input wire logic [3:0] resolution_code_i,
   quad_link_if.receiver link,
   output logic [ANGLE_W-1:0] position_o,
   output logic marker_seen_o,
   output logic error_o
);
   // ==========================================================
   // State decode
   logic [1:0] prev_ff;
   logic [1:0] cur_pos;
   logic [1:0] delta;
   logic [3:0] shift;
   logic [ANGLE_W-1:0] mask;
   logic [ANGLE_W-1:0] pos_ff;
   logic err_ff;
   logic mk_ff;

   assign cur_pos = {link.chan_a, link.chan_a ^ link.chan_b};
   assign delta = cur_pos - prev_ff;
   assign shift = (resolution_code_i >= RES_CODE_MIN && resolution_code_i <= RES_CODE_MAX) ?
                  resolution_code_i - RES_SHIFT_BASE : RES_CODE_DEFAULT - RES_SHIFT_BASE;
   assign mask = {ANGLE_W{1'b1}} >> shift;

   always_ff @(posedge clk_sys_i)
   begin
      if (!nrst_i)
      begin
         prev_ff <= QPOS_0;
         pos_ff <= '0;
         err_ff <= 1'b0;
         mk_ff <= 1'b0;
      end
      else
      begin
         prev_ff <= cur_pos;
         mk_ff <= link.marker;
         if (delta == QPOS_1)
         begin
            pos_ff <= (pos_ff + 1'b1) & mask;
         end
         else if (delta == QPOS_3)
         begin
            pos_ff <= (pos_ff - 1'b1) & mask;
         end
         else if (delta == QPOS_2)
         begin
            err_ff <= 1'b1;
         end
      end
   end

   assign position_o = pos_ff;
   assign marker_seen_o = mk_ff;
   assign error_o = err_ff;
endmodule : quadrature_receiver
`default_nettype wire

/* verification/quad_link_assertions.sv */
// Checker for the three-wire quadrature link between the two ends.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
module quad_link_assertions
   import quad_enc_pkg::*;
(
   input wire logic clk_sys_i,
   input wire logic nrst_i,
   input wire logic chan_a,
   input wire logic chan_b,
   input wire logic marker
);
   // ==========================================================
   // Link properties
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (!nrst_i);
   logic [1:0] pos;
   assign pos = {chan_a, chan_a ^ chan_b};
   sequence step_s;
      !$stable(pos);
   endsequence
   reset_state_a: assert property ($rose(nrst_i) |-> !chan_a && !chan_b && marker)
      else $error("link not at zero state after reset");
   gray_a_only_a: assert property ($changed(chan_a) |-> $stable(chan_b))
      else $error("both channels changed together");
   gray_b_only_a: assert property ($changed(chan_b) |-> $stable(chan_a))
      else $error("both channels changed together");
   adjacent_step_a: assert property (step_s |-> (pos - $past(pos) == 2'h1) || ($past(pos) - pos == 2'h1))
      else $error("state skipped");
   marker_zero_a: assert property (marker |-> pos == QPOS_0)
      else $error("marker outside zero state");
   marker_rise_a: assert property ($rose(marker) |-> step_s)
      else $error("marker rose without a state change");
   marker_hold_a: assert property ($stable(pos) |-> $stable(marker))
      else $error("marker moved while state held");
   marker_fall_a: assert property ($fell(marker) |-> $past(pos) == QPOS_0 && pos != QPOS_0)
      else $error("marker fell at wrong place");
endmodule : quad_link_assertions
`default_nettype wire

/* verification/quadrature_encoder_output_tb_top.sv */
// Bench joining encoder output and receiver over the link interface.
// Assumes a 50 MHz clock; expected counts come from angle and code.
`timescale 1ns/1ps
`default_nettype none
module quadrature_encoder_output_tb_top;
   import quad_enc_pkg::*;
   logic clk_sys_i = 1'b0;
   logic nrst_i = 1'b0;
   logic [ANGLE_W-1:0] angle = '0;
   logic angle_valid = 1'b0;
   logic [3:0] code = 4'hE;
   logic [STEP_W-1:0] step = 16'h0000;
   logic settled, marker_seen, error;
   logic [ANGLE_W-1:0] position;
   logic [1:0] ab;
   logic [1:0] prev_ab = 2'h0;
   int failures = 0;
   int compares = 0;
   int gap = 1000;
   int min_gap = 1000;
   int n, k, c;
   quad_link_if quad_link_if_i ();
   incremental_encoder_output incremental_encoder_output_i (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i),
      .angle_i(angle), .angle_valid_i(angle_valid), .resolution_code_i(code),
      .quadrature_step_interval_i(step), .link(quad_link_if_i.encoder), .settled_o(settled));
   quadrature_receiver quadrature_receiver_i (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i),
      .resolution_code_i(code), .link(quad_link_if_i.receiver), .position_o(position),
      .marker_seen_o(marker_seen), .error_o(error));
   quad_link_assertions quad_link_assertions_i (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i),
      .chan_a(quad_link_if_i.chan_a), .chan_b(quad_link_if_i.chan_b), .marker(quad_link_if_i.marker));
   assign ab = {quad_link_if_i.chan_a, quad_link_if_i.chan_b};
   initial
   begin
      forever #10 clk_sys_i = ~clk_sys_i;
   end
   // ==========================================================
   // Step spacing monitor
   always @(posedge clk_sys_i)
   begin
      prev_ab <= ab;
      gap <= (ab != prev_ab) ? 1 : gap + 1;
      if (!nrst_i)
         min_gap <= 1000;
      else if (ab != prev_ab && gap < min_gap)
         min_gap <= gap;
   end
   // ==========================================================
   // Tasks
   task final_report;
      $display("compares=%0d failures=%0d", compares, failures);
      if (failures == 0 && compares > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : final_report
   task check(input logic [15:0] got, input logic [15:0] exp);
      compares++;
      if (got !== exp)
      begin
         failures++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : check
   task do_reset(input logic [3:0] rc, input logic [STEP_W-1:0] si);
      @(posedge clk_sys_i);
      nrst_i <= 1'b0;
      code <= rc;
      step <= si;
      angle <= '0;
      repeat (8) @(posedge clk_sys_i);
      nrst_i <= 1'b1;
   endtask : do_reset
   task send(input logic [ANGLE_W-1:0] a);
      @(posedge clk_sys_i);
      angle <= a;
      angle_valid <= 1'b1;
      @(posedge clk_sys_i);
      angle_valid <= 1'b0;
      repeat (3) @(negedge clk_sys_i);
      for (n = 0; n < 20000 && settled !== 1'b1; n++)
         @(negedge clk_sys_i);
      if (settled !== 1'b1)
      begin
         failures++;
         final_report();
      end
      repeat (3) @(negedge clk_sys_i);
   endtask : send
   // ==========================================================
   // Tests
   initial
   begin
      do_reset(4'hE, 16'h0000);
      @(negedge clk_sys_i);
      check(16'({ab, quad_link_if_i.marker}), 16'h0001);
      check(16'(position), 16'h0000);
      @(negedge clk_sys_i);
      check(16'(marker_seen), 16'h0001);
      send(14'h1000);
      check(16'(ab), 16'h0001);
      check(16'(n <= 3), 16'h0001);
      check(16'(position), 16'h0001);
      check(16'(marker_seen), 16'h0000);
      $display("test 1 done");
      do_reset(4'hC, 16'h0004);
      send(14'h3800);
      check(16'(position), 16'h000E);
      check(16'(ab), 16'h0003);
      check(16'(n <= 12), 16'h0001);
      check(16'(min_gap >= 4), 16'h0001);
      send(14'h0C00);
      check(16'(position), 16'h0003);
      check(16'(ab), 16'h0002);
      check(16'(n >= 12 && n <= 24), 16'h0001);
      check(16'(error), 16'h0000);
      $display("test 2 done");
      for (k = 0; k < 16; k++)
      begin
         c = (k < 3 || k > 14) ? 14 : k;
         do_reset(4'(k), 16'h0001);
         send(14'h3FFF);
         check(16'(position), 16'((1 << (16 - c)) - 1));
         check(16'(ab), 16'h0002);
         check(16'(error), 16'h0000);
      end
      $display("test 3 done");
      final_report();
   end
endmodule : quadrature_encoder_output_tb_top
`default_nettype wire
